// ==== design/l2ctag_consts.svh ====
`ifndef L2CTAG_CONSTS_SVH
`define L2CTAG_CONSTS_SVH
// Cache size codes
`define L2CTAG_SIZE_256K   2'h0
`define L2CTAG_SIZE_512K   2'h1
`define L2CTAG_SIZE_1M     2'h2
`define L2CTAG_SIZE_RESET  2'h0
// Tag bus field positions
`define L2CTAG_TAG_HI_BIT  8
`define L2CTAG_VALID_BIT   7
`define L2CTAG_DIRTY_BIT   6
// Host address bit that feeds tag bit 8
`define L2CTAG_ADDR_TOP    26
// Last beat index of a burst
`define L2CTAG_BURST_LAST  2'h3
`endif

// ==== design/l2ctag_pkg.sv ====
`default_nettype none
package l2ctag_pkg;
  typedef enum logic [2:0] {
    L2CTAG_IDLE, L2CTAG_LOOKUP, L2CTAG_BURST, L2CTAG_TAGWR
  } l2ctag_state_type;

  typedef struct packed {
    logic        valid;
    logic        fill;
    logic        write;
    logic        burst;
    logic [26:0] addr;
    logic [7:0]  byte_n;
  } l2ctag_req_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic dirty;
  } l2ctag_resp_type;

  typedef struct packed {
    logic       sram_burst_advance_n;
    logic       sram_ctrl_addr_strobe_n;
    logic       sram_chip_select_n;
    logic       sram_global_write_n;
    logic       sram_output_enable_n;
    logic [7:0] sram_byte_write_n;
  } l2ctag_sram_type;

  typedef struct packed {
    l2ctag_state_type state;
    l2ctag_req_type   req;
    logic [1:0]       size;
    logic [1:0]       beat;
    logic             mark_dirty;
    l2ctag_resp_type  resp;
    l2ctag_sram_type  sram;
    logic [8:0]       tag_bus;
    logic             tag_oe;
    logic             tag_write_n;
    logic             busy;
  } l2ctag_regs_type;
endpackage
`default_nettype wire

// ==== design/l2ctag_top.sv ====
`include "l2ctag_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module l2ctag_top (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESET,
  // Configuration
  input  wire logic                      CFG_LOAD,
  input  wire logic [1:0]                CFG_SIZE,
  // Host request and answer
  input  wire l2ctag_pkg::l2ctag_req_type REQ,
  output var  l2ctag_pkg::l2ctag_resp_type RESP,
  output var  logic                      BUSY,
  // Data SRAM control
  output var  l2ctag_pkg::l2ctag_sram_type SRAM,
  // Tag SRAM
  input  wire logic [8:0]                TAG_BUS_IN,
  output var  logic [8:0]                TAG_BUS_OUT,
  output var  logic                      TAG_BUS_OE,
  output var  logic                      TAG_WRITE_N
);
  import l2ctag_pkg::*;

  l2ctag_regs_type s;
  l2ctag_regs_type next_s;

  // Tag word layout per cache size
  function automatic logic [8:0] make_tag(input logic [26:0] a, input logic [1:0] sz,
                                          input logic d);
    logic [8:0] t;
    t = a[26:18];
    if (sz == `L2CTAG_SIZE_512K) begin
      t = {a[`L2CTAG_ADDR_TOP], 1'b1, a[25:19]};
    end else if (sz == `L2CTAG_SIZE_1M) begin
      t = {a[`L2CTAG_ADDR_TOP], 1'b1, d, a[25:20]};
    end
    t[`L2CTAG_TAG_HI_BIT] = a[`L2CTAG_ADDR_TOP];
    return t;
  endfunction

  function automatic logic tag_hit(input logic [26:0] a, input logic [1:0] sz,
                                   input logic [8:0] t);
    logic h;
    h = (t == a[26:18]);
    if (sz == `L2CTAG_SIZE_512K) begin
      h = t[`L2CTAG_VALID_BIT] && (t[6:0] == a[25:19]) &&
          (t[`L2CTAG_TAG_HI_BIT] == a[`L2CTAG_ADDR_TOP]);
    end else if (sz == `L2CTAG_SIZE_1M) begin
      h = t[`L2CTAG_VALID_BIT] && (t[5:0] == a[25:20]) &&
          (t[`L2CTAG_TAG_HI_BIT] == a[`L2CTAG_ADDR_TOP]);
    end
    return h;
  endfunction

  // Launch of a data access, shared by hits and fills
  function automatic l2ctag_sram_type launch(input l2ctag_req_type r);
    l2ctag_sram_type p;
    p = '{sram_burst_advance_n: 1'b1, sram_ctrl_addr_strobe_n: 1'b0,
          sram_chip_select_n: 1'b0, sram_global_write_n: 1'b1,
          sram_output_enable_n: 1'b1, sram_byte_write_n: 8'hff};
    if (!(r.write || r.fill)) begin
      p.sram_output_enable_n = 1'b0;
    end else if (r.fill || r.byte_n == 8'h00) begin
      p.sram_global_write_n = 1'b0;
    end else begin
      p.sram_byte_write_n = r.byte_n;
    end
    return p;
  endfunction

  always_comb begin
    next_s = s;
    next_s.resp.valid = 1'b0;
    next_s.sram.sram_ctrl_addr_strobe_n = 1'b1;
    next_s.sram.sram_chip_select_n = 1'b1;
    next_s.sram.sram_burst_advance_n = 1'b1;
    next_s.tag_write_n = 1'b1;
    // Size changes only between accesses; unused code ignored
    if (CFG_LOAD && s.state == L2CTAG_IDLE && CFG_SIZE != 2'h3) begin
      next_s.size = CFG_SIZE;
    end
    unique case (s.state)
      L2CTAG_IDLE: begin
        next_s.sram.sram_output_enable_n = 1'b1;
        next_s.sram.sram_global_write_n = 1'b1;
        next_s.sram.sram_byte_write_n = 8'hff;
        next_s.tag_oe = 1'b0;
        if (REQ.valid && !CFG_LOAD) begin
          next_s.req = REQ;
          next_s.mark_dirty = 1'b0;
          if (REQ.fill) begin
            next_s.tag_bus = make_tag(REQ.addr, s.size, REQ.write);
            next_s.tag_oe = 1'b1;
            next_s.tag_write_n = 1'b0;
            next_s.state = L2CTAG_TAGWR;
          end else begin
            next_s.state = L2CTAG_LOOKUP;
          end
        end
      end
      L2CTAG_LOOKUP: begin
        // Tag SRAM answers one cycle after the address
        next_s.resp.valid = 1'b1;
        next_s.resp.hit = tag_hit(s.req.addr, s.size, TAG_BUS_IN);
        next_s.resp.dirty = (s.size == `L2CTAG_SIZE_1M) && TAG_BUS_IN[`L2CTAG_DIRTY_BIT];
        next_s.state = L2CTAG_IDLE;
        if (tag_hit(s.req.addr, s.size, TAG_BUS_IN)) begin
          next_s.sram = launch(s.req);
          next_s.beat = 2'h0;
          next_s.mark_dirty = s.req.write && (s.size == `L2CTAG_SIZE_1M) &&
                              !TAG_BUS_IN[`L2CTAG_DIRTY_BIT];
          next_s.state = L2CTAG_BURST;
        end
      end
      L2CTAG_BURST: begin
        if (s.req.burst && s.beat != `L2CTAG_BURST_LAST) begin
          next_s.sram.sram_burst_advance_n = 1'b0;
          next_s.beat = s.beat + 2'h1;
        end else if (s.mark_dirty) begin
          next_s.sram.sram_output_enable_n = 1'b1;
          next_s.sram.sram_global_write_n = 1'b1;
          next_s.sram.sram_byte_write_n = 8'hff;
          next_s.tag_bus = make_tag(s.req.addr, s.size, 1'b1);
          next_s.tag_oe = 1'b1;
          next_s.tag_write_n = 1'b0;
          next_s.mark_dirty = 1'b0;
          next_s.state = L2CTAG_TAGWR;
        end else begin
          next_s.sram.sram_output_enable_n = 1'b1;
          next_s.sram.sram_global_write_n = 1'b1;
          next_s.sram.sram_byte_write_n = 8'hff;
          next_s.state = L2CTAG_IDLE;
        end
      end
      L2CTAG_TAGWR: begin
        // Tag data held one cycle past the write edge
        next_s.state = L2CTAG_IDLE;
        if (s.req.fill) begin
          next_s.req.fill = 1'b0;
          next_s.req.write = 1'b1;
          next_s.req.byte_n = 8'h00;
          next_s.sram = launch(s.req);
          next_s.beat = 2'h0;
          next_s.state = L2CTAG_BURST;
        end
      end
      default: begin
        next_s.state = L2CTAG_IDLE;
      end
    endcase
    // Busy from a flop, not a state decode
    next_s.busy = (next_s.state != L2CTAG_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s.state <= L2CTAG_IDLE;
      s.req <= '0;
      s.size <= `L2CTAG_SIZE_RESET;
      s.beat <= 2'h0;
      s.mark_dirty <= 1'b0;
      s.resp <= '0;
      s.sram <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'hff};
      s.tag_bus <= 9'h000;
      s.tag_oe <= 1'b0;
      s.tag_write_n <= 1'b1;
      s.busy <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign RESP = s.resp;
  assign BUSY = s.busy;
  assign SRAM = s.sram;
  assign TAG_BUS_OUT = s.tag_bus;
  assign TAG_BUS_OE = s.tag_oe;
  assign TAG_WRITE_N = s.tag_write_n;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  sequence launch_burst_s;
    !s.sram.sram_ctrl_addr_strobe_n && s.req.burst;
  endsequence
  sequence three_steps_s;
    (!s.sram.sram_burst_advance_n)[*3] ##1 s.sram.sram_burst_advance_n;
  endsequence

  chk_burst_steps: assert property (launch_burst_s |=> three_steps_s)
    else $error("burst advance not three beats");
  chk_strobe_select: assert property (
    !s.sram.sram_ctrl_addr_strobe_n |-> !s.sram.sram_chip_select_n &&
    s.sram.sram_burst_advance_n)
    else $error("strobe without chip select");
  chk_select_only: assert property (
    !s.sram.sram_chip_select_n |-> !s.sram.sram_ctrl_addr_strobe_n)
    else $error("chip select outside launch");
  chk_global_lanes: assert property (
    !s.sram.sram_global_write_n |-> s.sram.sram_byte_write_n == 8'hff &&
    s.sram.sram_output_enable_n && s.req.byte_n == 8'h00)
    else $error("global write on partial write");
  chk_read_enable: assert property (
    !s.sram.sram_output_enable_n |-> !s.req.write && !s.req.fill &&
    s.sram.sram_global_write_n)
    else $error("output enable on write");
  chk_byte_lanes: assert property (
    s.sram.sram_byte_write_n != 8'hff |-> s.sram.sram_byte_write_n == s.req.byte_n)
    else $error("wrong byte lanes");
  chk_small_layout: assert property (
    !s.tag_write_n && s.size == `L2CTAG_SIZE_256K |->
    s.tag_bus[7:0] == s.req.addr[25:18])
    else $error("256K tag layout wrong");
  chk_mid_valid: assert property (
    !s.tag_write_n && s.size == `L2CTAG_SIZE_512K |->
    s.tag_bus[7] && s.tag_bus[6:0] == s.req.addr[25:19])
    else $error("512K tag layout wrong");
  chk_big_dirty: assert property (
    !s.tag_write_n && s.size == `L2CTAG_SIZE_1M && !s.req.fill |->
    s.tag_bus[7:6] == 2'h3 && s.tag_bus[5:0] == s.req.addr[25:20])
    else $error("1M dirty tag wrong");
  chk_tag_top: assert property (
    !s.tag_write_n |-> s.tag_bus[8] == s.req.addr[26])
    else $error("tag bit 8 wrong");
  chk_tag_drive: assert property (
    !s.tag_write_n |-> s.tag_oe ##1 (s.tag_oe && s.tag_write_n))
    else $error("tag write without drive");
  chk_reset_idle: assert property (
    $past(RESET) |-> s.state == L2CTAG_IDLE && s.size == `L2CTAG_SIZE_RESET)
    else $error("reset state wrong");
  chk_hit_valid: assert property (
    s.resp.valid && s.resp.hit && s.size != `L2CTAG_SIZE_256K |->
    $past(TAG_BUS_IN[7]))
    else $error("hit with valid clear");

  sequence fill_tag_store_s;
    !s.tag_write_n && s.req.fill;
  endsequence
  sequence fill_launch_s;
    !s.sram.sram_ctrl_addr_strobe_n && !s.sram.sram_global_write_n &&
    s.sram.sram_byte_write_n == 8'hff;
  endsequence

  chk_fill_order: assert property (fill_tag_store_s |=> fill_launch_s)
    else $error("fill launch missing after tag write");
  chk_lookup_answer: assert property (s.state == L2CTAG_LOOKUP |=> s.resp.valid)
    else $error("lookup gave no answer");
  chk_answer_source: assert property (
    s.resp.valid |-> $past(s.state) == L2CTAG_LOOKUP)
    else $error("answer without lookup");
  chk_miss_quiet: assert property (
    s.resp.valid && !s.resp.hit |-> s.sram.sram_chip_select_n && s.state == L2CTAG_IDLE)
    else $error("data access on miss");
  chk_dirty_size: assert property (
    s.resp.valid && s.size != `L2CTAG_SIZE_1M |-> !s.resp.dirty)
    else $error("dirty answer outside 1M");
  chk_small_hit: assert property (
    s.resp.valid && s.size == `L2CTAG_SIZE_256K |->
    s.resp.hit == ($past(TAG_BUS_IN) == s.req.addr[26:18]))
    else $error("256K hit compare wrong");
  chk_adv_in_burst: assert property (
    !s.sram.sram_burst_advance_n |-> s.state == L2CTAG_BURST && s.req.burst)
    else $error("advance outside burst");
  chk_lookup_listen: assert property (
    s.state == L2CTAG_LOOKUP |-> !s.tag_oe && s.tag_write_n)
    else $error("tag bus driven during lookup");
  chk_idle_quiet: assert property (
    s.state == L2CTAG_IDLE |-> s.sram.sram_output_enable_n &&
    s.sram.sram_global_write_n && s.sram.sram_byte_write_n == 8'hff)
    else $error("data enables left on in idle");
  chk_busy_state: assert property (
    s.busy == (s.state != L2CTAG_IDLE))
    else $error("busy flag disagrees with state");
endmodule

`default_nettype wire

// ==== verification/l2ctag_tag_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Tag SRAM: one word per line slot
module l2ctag_tag_model (
  // Clock
  input  wire logic       clk,
  // Controller side
  input  wire logic [3:0] idx,
  input  wire logic [8:0] tag_out,
  input  wire logic       tag_oe,
  input  wire logic       tag_write_n,
  // Resolved bus back to controller
  output logic [8:0]      tag_in
);
  logic [8:0] mem [16];
  // Unwritten slots read all ones, never unknown
  initial foreach (mem[i]) mem[i] = 9'h1ff;
  always @(posedge clk) if (!tag_write_n) mem[idx] <= tag_out;
  // Bus level: controller wins while it drives
  assign tag_in = tag_oe ? tag_out : mem[idx];
endmodule
`default_nettype wire

// ==== verification/test_l2_cache_sram_tag_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_l2_cache_sram_tag_control;
  import l2ctag_pkg::*;
  typedef struct packed {
    logic [1:0] sz; logic [26:0] fa; logic [26:0] la;
    logic w; logic b; logic [7:0] be; logic hit;
  } l2ctag_row_type;
  // Fill address, lookup address, expected hit
  localparam l2ctag_row_type ROWS [6] = '{
    '{2'h0, 27'h5a40003, 27'h5a40003, 1'b0, 1'b1, 8'hff, 1'b1},
    '{2'h0, 27'h5a40003, 27'h5a00003, 1'b0, 1'b0, 8'hff, 1'b0},
    '{2'h1, 27'h7f80005, 27'h7f80005, 1'b1, 1'b1, 8'h00, 1'b1},
    '{2'h1, 27'h7f80005, 27'h3f80005, 1'b0, 1'b1, 8'hff, 1'b0},
    '{2'h2, 27'h0f00006, 27'h0f00006, 1'b1, 1'b0, 8'hf0, 1'b1},
    '{2'h2, 27'h0f00007, 27'h0e00007, 1'b0, 1'b1, 8'hff, 1'b0}};
  logic CLK = 1'b0;
  logic RESET, CFG_LOAD, BUSY, TAG_BUS_OE, TAG_WRITE_N;
  logic [1:0] CFG_SIZE;
  logic [8:0] TAG_BUS_IN, TAG_BUS_OUT, tag;
  l2ctag_req_type req;
  l2ctag_resp_type RESP;
  l2ctag_sram_type SRAM;
  l2ctag_row_type r;
  int err_count = 0, cmp_count = 0, adv, rv, twn;
  logic st, cs, oe, gw, hit, dty, toe;
  logic [7:0] lanes;
  always #12.5 CLK = ~CLK;
  l2ctag_top i_dut (.CLK(CLK), .RESET(RESET), .CFG_LOAD(CFG_LOAD), .CFG_SIZE(CFG_SIZE),
    .REQ(req), .RESP(RESP), .BUSY(BUSY), .SRAM(SRAM), .TAG_BUS_IN(TAG_BUS_IN),
    .TAG_BUS_OUT(TAG_BUS_OUT), .TAG_BUS_OE(TAG_BUS_OE), .TAG_WRITE_N(TAG_WRITE_N));
  l2ctag_tag_model i_tag (.clk(CLK), .idx(req.addr[3:0]), .tag_out(TAG_BUS_OUT),
    .tag_oe(TAG_BUS_OE), .tag_write_n(TAG_WRITE_N), .tag_in(TAG_BUS_IN));
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [8:0] exp_tag(logic [1:0] s, logic [26:0] a, logic d);
    case (s)
      2'h0: exp_tag = a[26:18];
      2'h1: exp_tag = {a[26], 1'b1, a[25:19]};
      default: exp_tag = {a[26], 1'b1, d, a[25:20]};
    endcase
  endfunction
  task automatic cfg(input logic [1:0] s);
    @(negedge CLK);
    CFG_LOAD = 1'b1;
    CFG_SIZE = s;
    @(negedge CLK);
    CFG_LOAD = 1'b0;
  endtask
  // One request, watched until the controller is idle again
  task automatic op(input logic f, w, b, input logic [26:0] a, input logic [7:0] be);
    int n;
    @(negedge CLK);
    req = '{1'b1, f, w, b, a, be};
    @(negedge CLK);
    req.valid = 1'b0;
    {adv, rv, twn, n} = '0;
    {st, cs, oe, gw, hit, dty, toe} = '0;
    lanes = 8'hff;
    tag = '0;
    do begin
      if (SRAM.sram_burst_advance_n === 1'b0) adv++;
      if (SRAM.sram_ctrl_addr_strobe_n === 1'b0) st = 1'b1;
      if (SRAM.sram_chip_select_n === 1'b0) cs = 1'b1;
      if (SRAM.sram_output_enable_n === 1'b0) oe = 1'b1;
      if (SRAM.sram_global_write_n === 1'b0) gw = 1'b1;
      lanes = lanes & SRAM.sram_byte_write_n;
      if (TAG_WRITE_N === 1'b0) begin
        twn++;
        tag = TAG_BUS_OUT;
        toe = TAG_BUS_OE;
      end
      if (RESP.valid === 1'b1) begin
        rv++;
        hit = RESP.hit;
        dty = RESP.dirty;
      end
      @(negedge CLK);
      n++;
    end while ((BUSY !== 1'b0 || n < 2) && n < 30);
    if (n >= 30) begin
      err_count++;
      $display("[FAIL] busy expected 0 seen 1");
      conclude();
    end
  endtask
  initial begin
    RESET = 1'b1;
    CFG_LOAD = 1'b0;
    CFG_SIZE = 2'h0;
    req = '0;
    repeat (6) @(negedge CLK);
    RESET = 1'b0;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      cfg(r.sz);
      op(1'b1, 1'b0, 1'b1, r.fa, 8'hff);
      chk("fill tag", {7'h0, exp_tag(r.sz, r.fa, 1'b0)}, {7'h0, tag});
      chk("fill tag writes", 16'h1, 16'(twn));
      chk("tag drive", 16'h1, {15'h0, toe});
      op(1'b0, r.w, r.b, r.la, r.be);
      chk("resp", {15'h1, r.hit}, {15'(rv), hit});
      chk("advances", (r.hit && r.b) ? 16'h3 : 16'h0, 16'(adv));
      chk("strobes", {12'h0, r.hit, r.hit, r.hit & ~r.w, r.hit & r.w & (r.be == 8'h00)},
          {12'h0, st, cs, oe, gw});
      chk("lanes", (r.hit && r.w && r.be != 8'h00) ? {8'h0, r.be} : 16'hff, {8'h0, lanes});
      chk("dirty writes", {15'h0, r.sz == 2'h2 && r.hit && r.w}, 16'(twn));
      if (r.sz == 2'h2 && r.hit && r.w)
        chk("dirty tag", {7'h0, exp_tag(r.sz, r.la, 1'b1)}, {7'h0, tag});
    end
    // Unused size code keeps 1 MB; second write hit sees dirty line
    cfg(2'h3);
    op(1'b0, 1'b1, 1'b0, ROWS[4].la, 8'h00);
    chk("dirty resp", 16'h3, {14'h0, hit, dty});
    chk("clean rewrite", 16'h0, 16'(twn));
    chk("full lanes", 16'h1, {15'h0, gw});
    // Reset in mid-access
    @(negedge CLK);
    req = '{1'b1, 1'b0, 1'b0, 1'b1, ROWS[4].fa, 8'hff};
    @(negedge CLK);
    req.valid = 1'b0;
    RESET = 1'b1;
    @(negedge CLK);
    chk("sram idle", 16'h1fff, {3'h0, SRAM});
    chk("busy", 16'h0, {15'h0, BUSY});
    chk("resp tag pins", 16'h1, {11'h0, RESP, TAG_BUS_OE, TAG_WRITE_N});
    @(negedge CLK);
    RESET = 1'b0;
    op(1'b1, 1'b0, 1'b1, 27'h7f80009, 8'hff);
    chk("default size", {7'h0, exp_tag(2'h0, 27'h7f80009, 1'b0)}, {7'h0, tag});
    conclude();
  end
endmodule
`default_nettype wire
